// *** pkg/plen_fifo_if.sv ***
// Connection between the channel logic and its packet-length FIFO
interface plen_fifo_if;
    import spw_capture_pkg::*;
    logic push;
    pkt_len_t push_len;
    logic pop;
    pkt_len_t head;
    plen_cnt_t count;
    logic empty;
    logic full;
    modport owner(output push, output push_len, output pop, input head, input count, input empty, input full);
    modport fifo(input push, input push_len, input pop, output head, output count, output empty, output full);
endinterface

// *** pkg/spw_capture_map.svh ***
// Register offsets, field positions, reset values and levels of the capture channel
`ifndef SPW_CAPTURE_MAP_SVH
`define SPW_CAPTURE_MAP_SVH
`define OFS_PKT_LEN 8'h28
`define OFS_RX_CHAIN 8'h2c
`define OFS_TX_CHAIN 8'h30
`define OFS_RX_DMA_PTR 8'h34
`define OFS_TX_START 8'h38
`define OFS_TX_END 8'h3c
`define OFS_RX_START 8'h40
`define OFS_RX_END 8'h44
`define OFS_MODE 8'h48
`define OFS_STATUS 8'h4c
`define PLEN_DEPTH 12'hfff
`define PLEN_LAST_PTR 12'hffe
`define PAUSE_LEVEL 12'hfdf
`define RST_TX_START 32'h0000_0000
`define RST_TX_END 32'h01ff_ffff
`define RST_RX_START 32'h0200_0000
`define RST_RX_END 32'h03ff_ffff
`define MODE_DISABLED 2'b00
`define MODE_DOWN_START 2'b01
`define MODE_UP_START 2'b10
`define STAT_PAUSE_BIT 0
`define STAT_OVF_LSB 16
`define STAT_OVF_MSB 31
`define LEN_MSB 30
`define LANE_LAST 2'h3
`define ZERO_WORD 32'h0000_0000
`endif

// *** pkg/spw_capture_pkg.sv ***
// Types shared by the capture channel modules
package spw_capture_pkg;
    typedef logic [31:0] word32_t;
    typedef logic [30:0] pkt_len_t;
    typedef logic [11:0] plen_cnt_t;
    typedef logic [1:0] mode_t;
    typedef logic [15:0] gray16_t;
    typedef enum logic [1:0] {CAP_IDLE, CAP_WAIT_LINK, CAP_WAIT_SYNC, CAP_RUN} capture_state_t;
    typedef struct packed {
        plen_cnt_t wr_ptr;
        plen_cnt_t rd_ptr;
        plen_cnt_t count;
    } fifo_state_t;
    typedef struct packed {
        capture_state_t cap_state;
        mode_t mode;
        word32_t tx_start;
        word32_t tx_end;
        word32_t rx_start;
        word32_t rx_end;
        word32_t tx_region_bytes;
        word32_t rx_region_bytes;
        word32_t rx_chain;
        word32_t tx_chain;
        word32_t dma_ptr;
        gray16_t rx_io_meta;
        gray16_t rx_io_gray;
        gray16_t tx_io_meta;
        gray16_t tx_io_gray;
        logic pause_seen;
        logic [15:0] ovf_cnt;
        word32_t word_buf;
        logic [1:0] lane;
        pkt_len_t pkt_bytes;
        logic word_valid;
        word32_t word_out;
        word32_t rdata;
        logic ack;
        logic active;
        logic paused;
    } top_state_t;
endpackage

// *** rtl/spw_capture_channel_regs.sv ***
// Capture channel registers, byte packer and packet-length bookkeeping
`include "spw_capture_map.svh"
module spw_capture_channel_regs (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Host register port
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire spw_capture_pkg::word32_t reg_wdata,
    output spw_capture_pkg::word32_t reg_rdata,
    output logic reg_ack,
    // Captured link traffic
    input wire logic link_up,
    input wire logic cap_byte_valid,
    input wire logic [7:0] cap_byte,
    input wire logic cap_eop,
    output logic cap_word_valid,
    output spw_capture_pkg::word32_t cap_word,
    output logic capture_active,
    output logic capture_paused,
    // Receive chain fill levels
    input wire spw_capture_pkg::gray16_t rx_io_cnt_gray,
    input wire logic [15:0] rx_dma_cnt,
    input wire spw_capture_pkg::word32_t rx_ddr_cnt,
    input wire logic [2:0] rx_pipe_cnt,
    // Transmit chain fill levels
    input wire spw_capture_pkg::gray16_t tx_io_cnt_gray,
    input wire logic [15:0] tx_dma_cnt,
    input wire spw_capture_pkg::word32_t tx_ddr_cnt,
    // Receive DMA address
    input wire spw_capture_pkg::word32_t rx_dma_addr,
    // DDR region bounds and sizes
    output spw_capture_pkg::word32_t tx_region_start,
    output spw_capture_pkg::word32_t tx_region_end,
    output spw_capture_pkg::word32_t rx_region_start,
    output spw_capture_pkg::word32_t rx_region_end,
    output spw_capture_pkg::word32_t tx_region_bytes,
    output spw_capture_pkg::word32_t rx_region_bytes
);
    import spw_capture_pkg::*;

    logic [1:0] rst_pipe;
    logic rst_n;
    top_state_t st;
    top_state_t next_st;
    logic pause;
    logic len_push;
    logic len_pop;
    pkt_len_t len_value;
    logic take_byte;
    logic last_byte;
    logic rd_hit_len;
    word32_t placed;
    // Chain count terms and region spans
    logic [15:0] rx_io_bin;
    logic [15:0] tx_io_bin;
    word32_t rx_sum;
    word32_t tx_sum;
    word32_t tx_span;
    word32_t rx_span;

    // Packet-length FIFO behind its interface
    plen_fifo_if plen ();

    spw_plen_fifo u_plen_fifo (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .port(plen.fifo)
    );

    // Gray to binary, msb first
    function automatic logic [15:0] gray_to_bin(input logic [15:0] g);
        logic [15:0] b;
        b = '0;
        b[15] = g[15];
        for (int i = 14; i >= 0; i--) begin
            b[i] = b[i + 1] ^ g[i];
        end
        return b;
    endfunction

    // Reset release through two flops
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rst_pipe <= 2'b00;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end
    assign rst_n = rst_pipe[1];

    assign pause = (plen.count >= `PAUSE_LEVEL);
    assign plen.push = len_push;
    assign plen.push_len = len_value;
    assign plen.pop = len_pop;

    // Link-domain counts leave gray code only after both sync flops
    assign rx_io_bin = gray_to_bin(st.rx_io_gray);
    assign tx_io_bin = gray_to_bin(st.tx_io_gray);
    assign rx_sum = {16'h0000, rx_io_bin} + {16'h0000, rx_dma_cnt}
        + rx_ddr_cnt + {29'h0000_0000, rx_pipe_cnt};
    assign tx_sum = {16'h0000, tx_dma_cnt} + {16'h0000, tx_io_bin} + tx_ddr_cnt;

    // Both bounds count as part of the region
    assign tx_span = st.tx_end - st.tx_start + 32'h0000_0001;
    assign rx_span = st.rx_end - st.rx_start + 32'h0000_0001;

    always_comb begin
        next_st = st;
        len_push = 1'b0;
        len_pop = 1'b0;
        len_value = '0;
        placed = st.word_buf;
        take_byte = 1'b0;
        last_byte = 1'b0;
        rd_hit_len = reg_rd && (reg_addr == `OFS_PKT_LEN);

        // Two-flop crossing of link-domain gray counts
        next_st.rx_io_meta = rx_io_cnt_gray;
        next_st.rx_io_gray = st.rx_io_meta;
        next_st.tx_io_meta = tx_io_cnt_gray;
        next_st.tx_io_gray = st.tx_io_meta;

        // Full chain sums, one count per word
        next_st.rx_chain = rx_sum;
        next_st.tx_chain = tx_sum;
        next_st.dma_ptr = rx_dma_addr;

        // Inclusive region sizes
        next_st.tx_region_bytes = tx_span;
        next_st.rx_region_bytes = rx_span;

        // Capture sequencing
        case (st.cap_state)
            CAP_IDLE: begin
                if (st.mode == `MODE_UP_START) begin
                    next_st.cap_state = CAP_WAIT_SYNC;
                end else if (st.mode != `MODE_DISABLED) begin
                    next_st.cap_state = CAP_WAIT_LINK;
                end
            end
            CAP_WAIT_LINK: begin
                if (st.mode == `MODE_UP_START) begin
                    next_st.cap_state = CAP_WAIT_SYNC;
                end else if (link_up) begin
                    next_st.cap_state = CAP_RUN;
                end
            end
            CAP_WAIT_SYNC: begin
                // Join a running link at a packet boundary
                if (st.mode != `MODE_UP_START) begin
                    next_st.cap_state = CAP_WAIT_LINK;
                end else if (link_up && cap_byte_valid && cap_eop) begin
                    next_st.cap_state = CAP_RUN;
                end
            end
            CAP_RUN: begin
                if (!link_up) begin
                    next_st.cap_state = (st.mode == `MODE_UP_START) ? CAP_WAIT_SYNC : CAP_WAIT_LINK;
                end
            end
            default: begin
                next_st.cap_state = CAP_IDLE;
            end
        endcase
        if (st.mode == `MODE_DISABLED) begin
            next_st.cap_state = CAP_IDLE;
        end

        // Byte packing
        next_st.word_valid = 1'b0;
        if (st.cap_state == CAP_RUN && link_up && cap_byte_valid) begin
            take_byte = 1'b1;
            placed = st.word_buf;
            placed[st.lane * 8 +: 8] = cap_byte;
            last_byte = cap_eop;
            if (st.lane == `LANE_LAST || cap_eop) begin
                next_st.word_valid = 1'b1;
                next_st.word_out = placed;
                next_st.word_buf = `ZERO_WORD;
                next_st.lane = 2'h0;
            end else begin
                next_st.word_buf = placed;
                next_st.lane = st.lane + 2'h1;
            end
            if (cap_eop) begin
                len_value = st.pkt_bytes + 31'h0000_0001;
                next_st.pkt_bytes = '0;
            end else begin
                next_st.pkt_bytes = st.pkt_bytes + 31'h0000_0001;
            end
        end else if (st.cap_state != CAP_RUN) begin
            // A packet cut by link loss or disable is dropped
            next_st.word_buf = `ZERO_WORD;
            next_st.lane = 2'h0;
            next_st.pkt_bytes = '0;
        end

        // Length store or refusal
        if (take_byte && last_byte) begin
            if (pause) begin
                next_st.ovf_cnt = st.ovf_cnt + 16'h0001;
            end else begin
                len_push = 1'b1;
            end
        end

        // Host register access
        next_st.ack = reg_rd || reg_wr;
        next_st.rdata = `ZERO_WORD;
        if (reg_wr) begin
            case (reg_addr)
                `OFS_TX_START: begin
                    next_st.tx_start = reg_wdata;
                end
                `OFS_TX_END: begin
                    next_st.tx_end = reg_wdata;
                end
                `OFS_RX_START: begin
                    next_st.rx_start = reg_wdata;
                end
                `OFS_RX_END: begin
                    next_st.rx_end = reg_wdata;
                end
                `OFS_MODE: begin
                    next_st.mode = reg_wdata[1:0];
                end
                `OFS_STATUS: begin
                    if (reg_wdata[`STAT_PAUSE_BIT]) begin
                        next_st.pause_seen = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end

        // Unmapped offsets read as zero
        if (reg_rd) begin
            case (reg_addr)
                `OFS_PKT_LEN: begin
                    next_st.rdata = {1'b0, plen.empty ? 31'h0000_0000 : plen.head};
                end
                `OFS_RX_CHAIN: begin
                    next_st.rdata = st.rx_chain;
                end
                `OFS_TX_CHAIN: begin
                    next_st.rdata = st.tx_chain;
                end
                `OFS_RX_DMA_PTR: begin
                    next_st.rdata = st.dma_ptr;
                end
                `OFS_TX_START: begin
                    next_st.rdata = st.tx_start;
                end
                `OFS_TX_END: begin
                    next_st.rdata = st.tx_end;
                end
                `OFS_RX_START: begin
                    next_st.rdata = st.rx_start;
                end
                `OFS_RX_END: begin
                    next_st.rdata = st.rx_end;
                end
                `OFS_MODE: begin
                    next_st.rdata = {30'h0000_0000, st.mode};
                end
                `OFS_STATUS: begin
                    next_st.rdata[`STAT_OVF_MSB:`STAT_OVF_LSB] = st.ovf_cnt;
                    next_st.rdata[`STAT_PAUSE_BIT] = st.pause_seen;
                end
                default: begin
                    next_st.rdata = `ZERO_WORD;
                end
            endcase
        end
        // Only a read of a stored length pops it
        if (rd_hit_len && !plen.empty) begin
            len_pop = 1'b1;
        end

        // Sticky pause: a new event wins over the host clear
        if (take_byte && last_byte && pause) begin
            next_st.pause_seen = 1'b1;
        end
        if (st.mode == `MODE_DISABLED) begin
            next_st.ovf_cnt = 16'h0000;
        end

        next_st.active = (next_st.cap_state == CAP_RUN);
        next_st.paused = pause;
    end

    // State register; bounds reset to their default areas
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
            st.cap_state <= CAP_IDLE;
            st.mode <= `MODE_DISABLED;
            st.tx_start <= `RST_TX_START;
            st.tx_end <= `RST_TX_END;
            st.rx_start <= `RST_RX_START;
            st.rx_end <= `RST_RX_END;
            st.pause_seen <= 1'b0;
            st.ovf_cnt <= 16'h0000;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from the state flops
    assign reg_rdata = st.rdata;
    assign reg_ack = st.ack;
    assign cap_word_valid = st.word_valid;
    assign cap_word = st.word_out;
    assign capture_active = st.active;
    assign capture_paused = st.paused;
    assign tx_region_start = st.tx_start;
    assign tx_region_end = st.tx_end;
    assign rx_region_start = st.rx_start;
    assign rx_region_end = st.rx_end;
    assign tx_region_bytes = st.tx_region_bytes;
    assign rx_region_bytes = st.rx_region_bytes;
endmodule // spw_capture_channel_regs

// *** rtl/spw_plen_fifo.sv ***
// Packet-length FIFO with show-ahead head word
`include "spw_capture_map.svh"
module spw_plen_fifo (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Channel side
    plen_fifo_if.fifo port
);
    import spw_capture_pkg::*;

    pkt_len_t mem [0:`PLEN_LAST_PTR];
    fifo_state_t st;
    fifo_state_t next_st;
    logic do_push;
    logic do_pop;

    assign port.head = mem[st.rd_ptr];
    assign port.count = st.count;
    assign port.empty = (st.count == 12'h000);
    assign port.full = (st.count == `PLEN_DEPTH);

    always_comb begin
        next_st = st;
        do_push = port.push && (st.count != `PLEN_DEPTH);
        do_pop = port.pop && (st.count != 12'h000);
        if (do_push) begin
            next_st.wr_ptr = (st.wr_ptr == `PLEN_LAST_PTR) ? 12'h000 : st.wr_ptr + 12'h001;
        end
        if (do_pop) begin
            next_st.rd_ptr = (st.rd_ptr == `PLEN_LAST_PTR) ? 12'h000 : st.rd_ptr + 12'h001;
        end
        if (do_push && !do_pop) begin
            next_st.count = st.count + 12'h001;
        end else if (do_pop && !do_push) begin
            next_st.count = st.count - 12'h001;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Storage carries no reset
    always_ff @(posedge ref_clk) begin
        if (do_push) begin
            mem[st.wr_ptr] <= port.push_len;
        end
    end
endmodule // spw_plen_fifo

// *** tb/spw_capture_assertions.sv ***
// Port-level assertions for the capture channel registers
`include "spw_capture_map.svh"
module spw_capture_assertions (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire spw_capture_pkg::word32_t reg_wdata,
    input wire spw_capture_pkg::word32_t reg_rdata,
    input wire logic reg_ack,
    // Capture and regions
    input wire logic cap_byte_valid,
    input wire logic cap_word_valid,
    input wire spw_capture_pkg::word32_t tx_region_start,
    input wire spw_capture_pkg::word32_t tx_region_end,
    input wire spw_capture_pkg::word32_t tx_region_bytes
);
    import spw_capture_pkg::*;
    logic [2:0] up_cnt;
    // Cycles since release, covers the internal reset delay
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            up_cnt <= 3'h0;
        end else if (up_cnt != 3'h7) begin
            up_cnt <= up_cnt + 3'h1;
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    sequence s_mode_wr;
        reg_wr && reg_addr == `OFS_MODE;
    endsequence
    sequence s_mode_rd;
        reg_rd && reg_addr == `OFS_MODE;
    endsequence
    property p_ack;
        (reg_rd || reg_wr) |=> reg_ack;
    endproperty
    a_ack: assert property (p_ack) else $error("access not acknowledged");
    property p_rdata_idle;
        !reg_ack |-> reg_rdata == 32'h0;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data without ack");
    property p_len_msb;
        reg_rd && reg_addr == `OFS_PKT_LEN |=> reg_ack && !reg_rdata[31];
    endproperty
    a_len_msb: assert property (p_len_msb) else $error("length bit 31 set");
    property p_unmapped;
        reg_rd && (reg_addr < `OFS_PKT_LEN || reg_addr > `OFS_STATUS) |=> reg_rdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_mode_rdbk;
        s_mode_wr ##2 s_mode_rd |=> reg_rdata == ($past(reg_wdata, 3) & 32'h3);
    endproperty
    a_mode_rdbk: assert property (p_mode_rdbk) else $error("mode read back wrong");
    property p_region_wr;
        reg_wr && reg_addr == `OFS_TX_START |=> tx_region_start == $past(reg_wdata);
    endproperty
    a_region_wr: assert property (p_region_wr) else $error("region start not written");
    property p_region_bytes;
        up_cnt == 3'h7 && $stable(tx_region_start) && $stable(tx_region_end)
            |-> tx_region_bytes == tx_region_end - tx_region_start + 32'h1;
    endproperty
    a_region_bytes: assert property (p_region_bytes) else $error("region size not inclusive");
    property p_word_src;
        cap_word_valid |-> $past(cap_byte_valid);
    endproperty
    a_word_src: assert property (p_word_src) else $error("word without byte");
endmodule // spw_capture_assertions
bind spw_capture_channel_regs spw_capture_assertions u_chk (.ref_clk, .rstn, .reg_addr, .reg_wr, .reg_rd,
    .reg_wdata, .reg_rdata, .reg_ack, .cap_byte_valid, .cap_word_valid, .tx_region_start, .tx_region_end,
    .tx_region_bytes);

// *** tb/spw_capture_channel_regs_tb_top.sv ***
// Self-checking bench for the capture channel registers
`include "spw_capture_map.svh"
module spw_capture_channel_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import spw_capture_pkg::*;
    logic ref_clk, rstn, reg_wr, reg_rd, reg_ack, link_up, cap_byte_valid, cap_eop, cap_word_valid;
    logic capture_active, capture_paused;
    logic [7:0] reg_addr, cap_byte;
    logic [2:0] rx_pipe_cnt;
    logic [15:0] rx_dma_cnt, tx_dma_cnt, v;
    gray16_t rx_io_cnt_gray, tx_io_cnt_gray;
    word32_t reg_wdata, reg_rdata, cap_word, rx_ddr_cnt, tx_ddr_cnt, rx_dma_addr, q, s, t;
    word32_t trs, tre, rrs, rre, txb, rxb;
    word32_t exp_q[$];
    int len_q[$];
    int error_cnt = 0, comparisons = 0, seed = 32'h96e1;
    bit chk_on = 1'b1;
    spw_link_node node (.ref_clk, .link_up, .cap_byte_valid, .cap_byte, .cap_eop);
    spw_capture_channel_regs dut (.ref_clk, .rstn, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_ack,
        .link_up, .cap_byte_valid, .cap_byte, .cap_eop, .cap_word_valid, .cap_word, .capture_active,
        .capture_paused, .rx_io_cnt_gray, .rx_dma_cnt, .rx_ddr_cnt, .rx_pipe_cnt, .tx_io_cnt_gray, .tx_dma_cnt,
        .tx_ddr_cnt, .rx_dma_addr, .tx_region_start(trs), .tx_region_end(tre), .rx_region_start(rrs),
        .rx_region_end(rre), .tx_region_bytes(txb), .rx_region_bytes(rxb));
    task automatic check(input string what, input word32_t seen, input word32_t exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrap_up();
        $display("%0d comparisons, %0d mismatches", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic access(input logic wr, input logic [7:0] a, input word32_t d);
        @(negedge ref_clk);
        reg_wr = wr;
        reg_rd = !wr;
        reg_addr = a;
        reg_wdata = d;
        @(negedge ref_clk);
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        check("ack", {31'h0, reg_ack}, 32'h1);
        q = reg_rdata;
    endtask
    task automatic rd_chk(input string what, input logic [7:0] a, input word32_t exp);
        access(1'b0, a, 32'h0);
        check(what, q, exp);
    endtask
    task automatic wait_active();
        int n;
        n = 0;
        while (capture_active !== 1'b1 && n < 20) begin
            @(negedge ref_clk);
            n++;
        end
        if (capture_active !== 1'b1) begin
            error_cnt++;
            wrap_up();
        end
    endtask
    // Expected words are packed here, byte 0 in the low lane
    task automatic send_pkt(input int len, input bit cap);
        word32_t w;
        logic [7:0] b;
        w = 32'h0;
        for (int i = 0; i < len; i++) begin
            b = 8'($random(seed));
            node.send(b, i == len - 1);
            w[8 * (i % 4) +: 8] = b;
            if (cap && (i % 4 == 3 || i == len - 1)) begin
                exp_q.push_back(w);
            end
            if (i % 4 == 3) begin
                w = 32'h0;
            end
        end
        node.idle();
        if (cap) begin
            len_q.push_back(len);
        end
    endtask
    always @(negedge ref_clk) begin
        if (chk_on && cap_word_valid === 1'b1) begin
            check("word", cap_word, exp_q.size() > 0 ? exp_q.pop_front() : 32'hdead_beef);
        end
    end
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (100000) @(posedge ref_clk);
        error_cnt++;
        wrap_up();
    end
    initial begin
        {rstn, reg_wr, reg_rd, reg_addr, reg_wdata, rx_pipe_cnt, rx_dma_cnt, tx_dma_cnt} = '0;
        {rx_io_cnt_gray, tx_io_cnt_gray, rx_ddr_cnt, tx_ddr_cnt, rx_dma_addr} = '0;
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
        rstn = 1'b1;
        repeat (4) @(negedge ref_clk);
        rd_chk("tx start", `OFS_TX_START, `RST_TX_START);
        rd_chk("tx end", `OFS_TX_END, `RST_TX_END);
        rd_chk("rx start", `OFS_RX_START, `RST_RX_START);
        rd_chk("rx end", `OFS_RX_END, `RST_RX_END);
        // Regions moved while capture is off
        for (int j = 0; j < 2; j++) begin
            s = $random(seed) & 32'hffff_f000;
            access(1'b1, 8'h38 + 8'(8 * j), s);
            access(1'b1, 8'h3c + 8'(8 * j), s + 32'h1fff);
            rd_chk("start", 8'h38 + 8'(8 * j), s);
            rd_chk("end", 8'h3c + 8'(8 * j), s + 32'h1fff);
            check("start pin", j ? rrs : trs, s);
            check("end pin", j ? rre : tre, s + 32'h1fff);
        end
        check("tx bytes", txb, 32'h2000);
        check("rx bytes", rxb, 32'h2000);
        rx_dma_addr = $random(seed);
        access(1'b1, `OFS_RX_DMA_PTR, ~rx_dma_addr);
        rd_chk("dma ptr", `OFS_RX_DMA_PTR, rx_dma_addr);
        access(1'b1, 8'h50, 32'hffff_ffff);
        rd_chk("unmapped", 8'h50, 32'h0);
        v = 16'($random(seed));
        rx_io_cnt_gray = v ^ (v >> 1);
        rx_dma_cnt = 16'($random(seed));
        rx_ddr_cnt = $random(seed) & 32'hfffff;
        rx_pipe_cnt = 3'($unsigned($random(seed)) % 5);
        s = {16'h0, v} + {16'h0, rx_dma_cnt} + rx_ddr_cnt + {29'h0, rx_pipe_cnt};
        v = 16'($random(seed));
        tx_io_cnt_gray = v ^ (v >> 1);
        tx_dma_cnt = 16'($random(seed));
        tx_ddr_cnt = $random(seed) & 32'hfffff;
        t = {16'h0, v} + {16'h0, tx_dma_cnt} + tx_ddr_cnt;
        repeat (6) @(negedge ref_clk);
        rd_chk("rx chain", `OFS_RX_CHAIN, s);
        rd_chk("tx chain", `OFS_TX_CHAIN, t);
        for (int m = 0; m < 4; m++) begin
            access(1'b1, `OFS_MODE, 32'hffff_fff0 | m);
            rd_chk("mode", `OFS_MODE, m);
        end
        $display("registers done");
        access(1'b1, `OFS_MODE, {30'h0, `MODE_DISABLED});
        node.set_link(1'b1);
        send_pkt(3, 1'b0);
        rd_chk("off len", `OFS_PKT_LEN, 32'h0);
        node.set_link(1'b0);
        access(1'b1, `OFS_MODE, {30'h0, `MODE_DOWN_START});
        repeat (5) @(negedge ref_clk);
        check("wait link", {31'h0, capture_active}, 32'h0);
        node.set_link(1'b1);
        wait_active();
        send_pkt(4, 1'b1);
        send_pkt(5, 1'b1);
        send_pkt(1, 1'b1);
        send_pkt(1 + $unsigned($random(seed)) % 9, 1'b1);
        repeat (3) @(negedge ref_clk);
        while (len_q.size() > 0) begin
            rd_chk("length", `OFS_PKT_LEN, len_q.pop_front());
        end
        rd_chk("empty len", `OFS_PKT_LEN, 32'h0);
        access(1'b1, `OFS_MODE, {30'h0, `MODE_DISABLED});
        access(1'b1, `OFS_MODE, {30'h0, `MODE_UP_START});
        repeat (3) @(negedge ref_clk);
        send_pkt(2, 1'b0);
        wait_active();
        send_pkt(6, 1'b1);
        repeat (3) @(negedge ref_clk);
        rd_chk("sync len", `OFS_PKT_LEN, 32'h6);
        rd_chk("sync empty", `OFS_PKT_LEN, 32'h0);
        $display("capture done");
        access(1'b1, `OFS_MODE, {30'h0, `MODE_DISABLED});
        access(1'b1, `OFS_MODE, 32'h3);
        wait_active();
        chk_on = 1'b0;
        // 4063 stored, then three refused
        repeat (4066) node.send(8'h5a, 1'b1);
        node.idle();
        repeat (3) @(negedge ref_clk);
        check("paused", {31'h0, capture_paused}, 32'h1);
        rd_chk("status", `OFS_STATUS, 32'h0003_0001);
        access(1'b1, `OFS_STATUS, 32'h1);
        rd_chk("status w1c", `OFS_STATUS, 32'h0003_0000);
        rd_chk("pop", `OFS_PKT_LEN, 32'h1);
        repeat (3) @(negedge ref_clk);
        check("unpaused", {31'h0, capture_paused}, 32'h0);
        access(1'b1, `OFS_MODE, {30'h0, `MODE_DISABLED});
        rd_chk("ovf clear", `OFS_STATUS, 32'h0);
        $display("pause done");
        wrap_up();
    end
endmodule // spw_capture_channel_regs_tb_top

// *** tb/spw_link_node.sv ***
// Link traffic source standing in for the monitored nodes
module spw_link_node (
    // Clock
    input wire logic ref_clk,
    // Captured traffic
    output logic link_up,
    output logic cap_byte_valid,
    output logic [7:0] cap_byte,
    output logic cap_eop
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        link_up = 1'b0;
        cap_byte_valid = 1'b0;
        cap_byte = 8'h00;
        cap_eop = 1'b0;
    end
    task automatic send(input logic [7:0] b, input logic eop);
        @(negedge ref_clk);
        cap_byte_valid = 1'b1;
        cap_byte = b;
        cap_eop = eop;
    endtask
    // Idle lane shows the inverse, never a stale byte
    task automatic idle();
        @(negedge ref_clk);
        cap_byte_valid = 1'b0;
        cap_eop = 1'b0;
        cap_byte = ~cap_byte;
    endtask
    task automatic set_link(input logic up);
        link_up = up;
    endtask
endmodule // spw_link_node
